// ### cfg_window_consts.svh
// offsets, field positions, reset values and masks of the window and error capability block
`ifndef CFG_WINDOW_CONSTS_SVH
`define CFG_WINDOW_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_WINDOW_POINTER 12'h0F8
`define OFS_WINDOW_DATA 12'h0FC
`define OFS_ERROR_CAP_HEADER 12'h100
`define OFS_UNCORRECTABLE_STATUS 12'h104

// ----------------------------------------------------------------
// window pointer fields
// ----------------------------------------------------------------
`define PTR_REG_LSB 2
`define PTR_REG_MSB 7
`define PTR_EXTENDED_REGISTER_NUMBER_FIELD_LSB 8
`define PTR_EXTENDED_REGISTER_NUMBER_FIELD_MSB 11
`define PTR_RESET 10'h000

// ----------------------------------------------------------------
// capability header fields
// ----------------------------------------------------------------
`define CAP_ID_VALUE 16'h0001
`define CAP_VERSION_VALUE 4'h1
`define CAP_NEXT_PTR_RESET 12'h180
`define CAP_NEXT_PTR_LSB 20

// ----------------------------------------------------------------
// uncorrectable status bit positions
// ----------------------------------------------------------------
`define ST_OBSOLETE 0
`define ST_LINK_PROTOCOL 4
`define ST_SURPRISE_DOWN 5
`define ST_POISONED 12
`define ST_FLOW_CONTROL 13
`define ST_COMPLETION_TIMEOUT 14
`define ST_COMPLETER_ABORT 15
`define ST_UNEXPECTED_COMPLETION 16
`define ST_RECEIVER_OVERFLOW 17
`define ST_MALFORMED 18
`define ST_END_TO_END_CRC 19
`define ST_UNSUPPORTED_REQUEST 20
`define ST_IMPLEMENTED_MASK 32'h001F3031
`define ST_RESET 32'h00000000

`endif

// ### cfg_window_pkg.sv
// types of the window and error capability block
package cfg_window_pkg;

    // ----------------------------------------------------------------
    // request sequencing
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle,
        st_remote
    } seq_e;

    typedef enum logic [2:0] {
        tgt_none,
        tgt_pointer,
        tgt_window,
        tgt_cap,
        tgt_status,
        tgt_remote
    } target_e;

    // ----------------------------------------------------------------
    // module state
    // ----------------------------------------------------------------
    typedef struct packed {
        seq_e state;
        logic ack;
        logic [31:0] rdata;
        logic [9:0] pointer;
        logic fwd_req;
        logic fwd_write;
        logic [11:0] fwd_addr;
        logic [3:0] fwd_be;
        logic [31:0] fwd_wdata;
    } window_s;

    typedef struct packed {
        logic [11:0] next_ptr;
    } cap_s;

    typedef struct packed {
        logic [31:0] status;
    } status_s;

endpackage : cfg_window_pkg

// ### error_cap_header.sv
// capability header with lockable next pointer
`timescale 1ns/10ps
`include "cfg_window_consts.svh"

module error_cap_header (
    input wire logic clock,
    input wire logic reset,
    input wire logic hot_reset,
    input wire logic lock,
    input wire logic wr_en,
    input wire logic [3:0] wr_be,
    input wire logic [31:0] wr_data,
    output logic [31:0] header
);

    cfg_window_pkg::cap_s q;
    cfg_window_pkg::cap_s d;

    // ----------------------------------------------------------------
    // next pointer update
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        if (hot_reset) begin
            d.next_ptr = `CAP_NEXT_PTR_RESET;
        end else if (wr_en && !lock) begin
            if (wr_be[2]) begin
                d.next_ptr[3:0] = wr_data[23:20]; // R7
            end
            if (wr_be[3]) begin
                d.next_ptr[11:4] = wr_data[31:24]; // R7
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '{next_ptr: `CAP_NEXT_PTR_RESET};
        end else begin
            q <= d;
        end
    end

    assign header = {q.next_ptr, `CAP_VERSION_VALUE, `CAP_ID_VALUE}; // R7 R8

endmodule : error_cap_header

// ### error_status_bank.sv
// sticky write-one-to-clear uncorrectable error status bits
`timescale 1ns/10ps
`include "cfg_window_consts.svh"

module error_status_bank (
    input wire logic clock,
    input wire logic reset,
    input wire logic [31:0] events,
    input wire logic surprise_down_capable,
    input wire logic clr_en,
    input wire logic [3:0] clr_be,
    input wire logic [31:0] clr_data,
    output logic [31:0] status
);

    cfg_window_pkg::status_s q;
    cfg_window_pkg::status_s d;
    logic [31:0] avail;
    logic [31:0] clr_bits;
    logic [31:0] nxt;

    // ----------------------------------------------------------------
    // per bit set and clear
    // ----------------------------------------------------------------
    always_comb begin
        avail = `ST_IMPLEMENTED_MASK; // R13 R14 R20
        avail[`ST_SURPRISE_DOWN] = surprise_down_capable; // R10
        clr_bits = '0;
        for (int b = 0; b < 4; b++) begin
            if (clr_en && clr_be[b]) begin
                clr_bits[b*8 +: 8] = clr_data[b*8 +: 8]; // R3
            end
        end
    end

    for (genvar i = 0; i < 32; i++) begin : g_bit
        // set wins over a clear in the same cycle
        assign nxt[i] = avail[i] & (events[i] | (q.status[i] & ~clr_bits[i])); // R9
    end

    assign d.status = nxt;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '{status: `ST_RESET}; // R22
        end else begin
            q <= d;
        end
    end

    assign status = q.status;

endmodule : error_status_bank

// ### cfg_window_aer.sv
// configuration data window and error reporting capability of one switch port
// Overview of operation
// R1: window read returns the register selected by the window pointer.
// R2: window write stores data into the register selected by the window pointer.
// R3: byte enables of a window access pass unchanged to the target register.
// R4: pointer at the data window itself: reads give zero, writes dropped.
// R5: pointer at itself: window writes update the window pointer.
// R6: side port window accesses read zero and never write anything.
// R7: header bits 15:0 read 0x1; bits 31:20 lockable pointer, reset 0x180.
// R8: header bits 19:16 read capability version 1.
// R9: bit 4 sets on link protocol error; sticky, write one clears.
// R10: bit 5 surprise down is sticky, cleared by one, zero when not capable.
// R11: bit 12 sets on a poisoned packet.
// R12: bit 13 sets on a flow control protocol error.
// R13: bit 14 completion timeout reads fixed zero.
// R14: bit 15 completer abort reads fixed zero.
// R15: bit 16 sets on an unexpected completion.
// R16: bit 17 sets on a receiver overflow.
// R17: bit 18 sets on a malformed packet.
// R18: bit 19 sets on an end-to-end crc error.
// R19: bit 20 sets on an unsupported request.
// R20: bit 0 obsolete sticky clear-only; bits 3:1, 11:6, 31:21 read zero.
// R21: pointer selects register number in bits 7:2, extension in 11:8.
// R22: sticky bits survive hot and link-down resets, only full reset clears.
`timescale 1ns/10ps
`include "cfg_window_consts.svh"

module cfg_window_aer (
    input wire logic clock,
    input wire logic reset,
    input wire logic hot_reset,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic cfg_smbus,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    output logic fwd_req,
    output logic fwd_write,
    output logic [11:0] fwd_addr,
    output logic [3:0] fwd_be,
    output logic [31:0] fwd_wdata,
    input wire logic fwd_ack,
    input wire logic [31:0] fwd_rdata,
    input wire logic next_ptr_lock,
    input wire logic surprise_down_capable,
    input wire logic link_protocol_error_flag,
    input wire logic surprise_down_flag,
    input wire logic poisoned_packet_flag,
    input wire logic flow_control_error_flag,
    input wire logic unexpected_completion_flag,
    input wire logic receiver_overflow_flag,
    input wire logic malformed_packet_flag,
    input wire logic end_to_end_crc_flag,
    input wire logic unsupported_request_flag,
    output logic [31:0] uncorrectable_status_reg
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8]; // R3
            end
        end
        return r;
    endfunction : merge_bytes

    function automatic cfg_window_pkg::target_e decode(input logic [11:0] addr,
                                                       input logic via_window);
        cfg_window_pkg::target_e t;
        case ({addr[11:2], 2'b00})
            `OFS_WINDOW_POINTER: t = cfg_window_pkg::tgt_pointer;
            `OFS_WINDOW_DATA: t = cfg_window_pkg::tgt_window;
            `OFS_ERROR_CAP_HEADER: t = cfg_window_pkg::tgt_cap;
            `OFS_UNCORRECTABLE_STATUS: t = cfg_window_pkg::tgt_status;
            default: t = via_window ? cfg_window_pkg::tgt_remote : cfg_window_pkg::tgt_none;
        endcase
        return t;
    endfunction : decode

    // ----------------------------------------------------------------
    // state and wiring
    // ----------------------------------------------------------------
    cfg_window_pkg::window_s q;
    cfg_window_pkg::window_s d;
    cfg_window_pkg::target_e direct_tgt;
    cfg_window_pkg::target_e window_tgt;
    cfg_window_pkg::target_e eff_tgt;
    logic [11:0] window_addr;
    logic use_window;
    logic take;
    logic cap_wr;
    logic status_clr;
    logic [31:0] pointer_word;
    logic [31:0] pointer_merged;
    logic [31:0] cap_word;
    logic [31:0] status_word;
    logic [31:0] events;

    assign window_addr = {q.pointer, 2'b00}; // R21
    assign pointer_word = {20'h00000, q.pointer, 2'b00}; // R21
    assign pointer_merged = merge_bytes(pointer_word, cfg_wdata, cfg_be); // R3 R5
    assign take = cfg_req && (q.state == cfg_window_pkg::st_idle);

    // ----------------------------------------------------------------
    // error events onto status bit positions
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[`ST_LINK_PROTOCOL] = link_protocol_error_flag; // R9
        events[`ST_SURPRISE_DOWN] = surprise_down_flag; // R10
        events[`ST_POISONED] = poisoned_packet_flag; // R11
        events[`ST_FLOW_CONTROL] = flow_control_error_flag; // R12
        events[`ST_UNEXPECTED_COMPLETION] = unexpected_completion_flag; // R15
        events[`ST_RECEIVER_OVERFLOW] = receiver_overflow_flag; // R16
        events[`ST_MALFORMED] = malformed_packet_flag; // R17
        events[`ST_END_TO_END_CRC] = end_to_end_crc_flag; // R18
        events[`ST_UNSUPPORTED_REQUEST] = unsupported_request_flag; // R19
    end

    // ----------------------------------------------------------------
    // target resolution
    // ----------------------------------------------------------------
    always_comb begin
        direct_tgt = decode(cfg_addr, 1'b0);
        window_tgt = decode(window_addr, 1'b1); // R1 R2
        use_window = (direct_tgt == cfg_window_pkg::tgt_window);
        if (!use_window) begin
            eff_tgt = direct_tgt;
        end else if (cfg_smbus) begin
            eff_tgt = cfg_window_pkg::tgt_none; // R6
        end else if (window_tgt == cfg_window_pkg::tgt_window) begin
            eff_tgt = cfg_window_pkg::tgt_none; // R4
        end else begin
            eff_tgt = window_tgt;
        end
    end

    // ----------------------------------------------------------------
    // request sequencing
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.fwd_req = 1'b0;
        cap_wr = 1'b0;
        status_clr = 1'b0;
        case (q.state)
            cfg_window_pkg::st_idle: begin
                if (take) begin
                    d.ack = 1'b1;
                    d.rdata = 32'h00000000;
                    case (eff_tgt)
                        cfg_window_pkg::tgt_pointer: begin
                            d.rdata = pointer_word; // R1
                            if (cfg_write) begin
                                d.pointer = pointer_merged[11:2]; // R5 R21
                            end
                        end
                        cfg_window_pkg::tgt_cap: begin
                            d.rdata = cap_word; // R1
                            cap_wr = cfg_write; // R2
                        end
                        cfg_window_pkg::tgt_status: begin
                            d.rdata = status_word; // R1
                            status_clr = cfg_write; // R2
                        end
                        cfg_window_pkg::tgt_remote: begin
                            d.ack = 1'b0;
                            d.state = cfg_window_pkg::st_remote;
                            d.fwd_req = 1'b1; // R1 R2
                            d.fwd_write = cfg_write;
                            d.fwd_addr = window_addr;
                            d.fwd_be = cfg_be; // R3
                            d.fwd_wdata = cfg_wdata;
                        end
                        default: begin
                            d.rdata = 32'h00000000; // R4 R6
                        end
                    endcase
                    if (cfg_write) begin
                        d.rdata = 32'h00000000;
                    end
                end
            end
            cfg_window_pkg::st_remote: begin
                if (fwd_ack) begin
                    d.ack = 1'b1;
                    d.rdata = q.fwd_write ? 32'h00000000 : fwd_rdata; // R1
                    d.state = cfg_window_pkg::st_idle;
                end
            end
            default: begin
                d.state = cfg_window_pkg::st_idle;
            end
        endcase
        if (hot_reset) begin
            d.pointer = `PTR_RESET; // R22
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            q <= '{state: cfg_window_pkg::st_idle, ack: 1'b0, rdata: 32'h00000000,
                   pointer: `PTR_RESET, fwd_req: 1'b0, fwd_write: 1'b0,
                   fwd_addr: 12'h000, fwd_be: 4'h0, fwd_wdata: 32'h00000000};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // capability header and status bank
    // ----------------------------------------------------------------
    error_cap_header u_cap (
        .clock(clock),
        .reset(reset),
        .hot_reset(hot_reset),
        .lock(next_ptr_lock),
        .wr_en(cap_wr),
        .wr_be(cfg_be),
        .wr_data(cfg_wdata),
        .header(cap_word)
    );

    error_status_bank u_status (
        .clock(clock),
        .reset(reset),
        .events(events),
        .surprise_down_capable(surprise_down_capable),
        .clr_en(status_clr),
        .clr_be(cfg_be),
        .clr_data(cfg_wdata),
        .status(status_word)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign cfg_ack = q.ack;
    assign cfg_rdata = q.rdata;
    assign fwd_req = q.fwd_req;
    assign fwd_write = q.fwd_write;
    assign fwd_addr = q.fwd_addr;
    assign fwd_be = q.fwd_be;
    assign fwd_wdata = q.fwd_wdata;
    assign uncorrectable_status_reg = status_word;

endmodule : cfg_window_aer

// ### cfg_window_aer_asserts.sv
// concurrent checks on the config window and error status ports
`timescale 1ns/10ps

module cfg_window_aer_checker (
    input wire logic clock,
    input wire logic reset,
    input wire logic cfg_req,
    input wire logic cfg_write,
    input wire logic cfg_smbus,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic fwd_req,
    input wire logic fwd_write,
    input wire logic [3:0] fwd_be,
    input wire logic fwd_ack,
    input wire logic [31:0] fwd_rdata,
    input wire logic surprise_down_capable,
    input wire logic link_protocol_error_flag,
    input wire logic poisoned_packet_flag,
    input wire logic unsupported_request_flag,
    input wire logic [31:0] uncorrectable_status_reg
);
    logic pend_q;
    logic pend_d;
    logic free;

    // tracks a forward between its request and its answer
    assign pend_d = fwd_req | (pend_q & ~fwd_ack);
    assign free = ~pend_q & ~fwd_req;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pend_q <= 1'h0;
        end else begin
            pend_q <= pend_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    AST_FIXED_ZERO: assert property ((uncorrectable_status_reg & 32'hFFE0CFCF) == 32'h0)
        else $error("reserved or fixed status bit set");
    AST_LINK_SET: assert property (link_protocol_error_flag |=> uncorrectable_status_reg[4])
        else $error("link protocol status not set");
    AST_POISON_SET: assert property (poisoned_packet_flag |=> uncorrectable_status_reg[12])
        else $error("poisoned status not set");
    AST_UR_SET: assert property (unsupported_request_flag |=> uncorrectable_status_reg[20])
        else $error("unsupported request status not set");
    AST_SD_GATED: assert property (!surprise_down_capable [*2] |-> !uncorrectable_status_reg[5])
        else $error("surprise down status set while not capable");
    AST_STICKY: assert property (uncorrectable_status_reg[12] && !(cfg_req && cfg_write)
        |=> uncorrectable_status_reg[12]) else $error("status bit lost without a write");
    AST_NO_SPURIOUS: assert property ($rose(uncorrectable_status_reg[12])
        |-> $past(poisoned_packet_flag)) else $error("status bit set without event");
    AST_HEADER_READ: assert property (cfg_req && free && !cfg_write && cfg_addr[11:2] == 10'h040
        |=> cfg_ack && cfg_rdata[19:0] == 20'h10001) else $error("bad header read");
    AST_SMBUS_READ: assert property (cfg_req && free && cfg_smbus && cfg_addr[11:2] == 10'h03F
        |=> cfg_ack && cfg_rdata == 32'h0 && !fwd_req) else $error("side port window not zero");
    AST_FWD_FIELDS: assert property (fwd_req |-> fwd_be == $past(cfg_be)
        && fwd_write == $past(cfg_write)) else $error("forward fields differ from request");
    AST_FWD_ANSWER: assert property (fwd_ack && pend_q && !fwd_write
        |=> cfg_ack && cfg_rdata == $past(fwd_rdata)) else $error("forward read data lost");
endmodule : cfg_window_aer_checker

bind cfg_window_aer cfg_window_aer_checker checker_i (
    .clock, .reset, .cfg_req, .cfg_write, .cfg_smbus, .cfg_addr, .cfg_be, .cfg_ack, .cfg_rdata,
    .fwd_req, .fwd_write, .fwd_be, .fwd_ack, .fwd_rdata, .surprise_down_capable,
    .link_protocol_error_flag, .poisoned_packet_flag, .unsupported_request_flag,
    .uncorrectable_status_reg
);

// ### fwd_target_model.sv
// behavioural far side that answers forwarded window accesses
`timescale 1ns/10ps

module fwd_target_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [3:0] ack_delay,
    input wire logic fwd_req,
    input wire logic fwd_write,
    input wire logic [11:0] fwd_addr,
    input wire logic [3:0] fwd_be,
    input wire logic [31:0] fwd_wdata,
    output logic fwd_ack,
    output logic [31:0] fwd_rdata
);
    logic [31:0] mem [0:1023];
    logic [31:0] rd;

    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 32'hC0DE0000 ^ i;
        fwd_ack = 1'h0;
        fwd_rdata = 32'h0;
    end

    // answers after a chosen delay, then shows the inverse of the last data
    always @(posedge clock) begin
        if (fwd_req === 1'h1 && !reset) begin
            repeat (ack_delay) @(posedge clock);
            for (int b = 0; b < 4; b++) begin
                if (fwd_write && fwd_be[b]) mem[fwd_addr[11:2]][8*b+:8] = fwd_wdata[8*b+:8];
            end
            rd = fwd_write ? ~mem[fwd_addr[11:2]] : mem[fwd_addr[11:2]];
            fwd_ack <= 1'h1;
            fwd_rdata <= rd;
            @(posedge clock);
            fwd_ack <= 1'h0;
            fwd_rdata <= ~rd;
        end
    end
endmodule : fwd_target_model

// ### tb_ext_cfg_access_aer_status.sv
// self-checking bench for the config window and error status block
`timescale 1ns/10ps
`include "cfg_window_consts.svh"

module tb_ext_cfg_access_aer_status;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic hot_reset, cfg_req, cfg_write, cfg_smbus, cfg_ack, fwd_req, fwd_write, fwd_ack;
    logic next_ptr_lock, surprise_down_capable;
    logic [11:0] cfg_addr, fwd_addr, a;
    logic [3:0] cfg_be, fwd_be, ack_delay, be;
    logic [31:0] cfg_wdata, cfg_rdata, fwd_wdata, fwd_rdata, uncorrectable_status_reg;
    logic [31:0] seed = 32'hD33CFBF6;
    logic [31:0] exp_st, d;
    logic [31:0] shadow [0:1023];
    logic [31:0] exp_q [$];
    logic [8:0] ev;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int pos [9] = '{4, 5, 12, 13, 16, 17, 18, 19, 20};

    always #2.5 clock = ~clock;

    cfg_window_aer uut (.clock, .reset, .hot_reset, .cfg_req, .cfg_write, .cfg_smbus, .cfg_addr,
        .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .fwd_req, .fwd_write, .fwd_addr, .fwd_be,
        .fwd_wdata, .fwd_ack, .fwd_rdata, .next_ptr_lock, .surprise_down_capable,
        .link_protocol_error_flag(ev[0]), .surprise_down_flag(ev[1]), .poisoned_packet_flag(ev[2]),
        .flow_control_error_flag(ev[3]), .unexpected_completion_flag(ev[4]),
        .receiver_overflow_flag(ev[5]), .malformed_packet_flag(ev[6]),
        .end_to_end_crc_flag(ev[7]), .unsupported_request_flag(ev[8]), .uncorrectable_status_reg);

    fwd_target_model partner (.clock, .reset, .ack_delay, .fwd_req, .fwd_write, .fwd_addr,
        .fwd_be, .fwd_wdata, .fwd_ack, .fwd_rdata);

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic final_report();
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report

    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    // ----------------------------------------------------------------
    // request driver and answer monitor
    // ----------------------------------------------------------------
    task automatic issue(input logic wr, input logic sm, input logic [11:0] ad,
                         input logic [3:0] bes, input logic [31:0] wd, input logic [31:0] exp,
                         input bit answered = 1'b1);
        @(negedge clock);
        cfg_req = 1'h1;
        cfg_write = wr;
        cfg_smbus = sm;
        cfg_addr = ad;
        cfg_be = bes;
        cfg_wdata = wd;
        if (answered) exp_q.push_back(exp);
    endtask : issue

    task automatic settle();
        @(negedge clock);
        cfg_req = 1'h0;
        for (int i = 0; i < 40 && exp_q.size() != 0; i++) @(negedge clock);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("[FAIL] cfg_ack expected 1 seen 0");
            exp_q.delete();
        end
    endtask : settle

    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        issue(1'h0, 1'h0, ad, 4'hF, xorshift(), exp);
        settle();
    endtask : rd

    task automatic wr(input logic [11:0] ad, input logic [3:0] bes, input logic [31:0] wd);
        issue(1'h1, 1'h0, ad, bes, wd, 32'h0);
        settle();
    endtask : wr

    task automatic pulse(input logic [8:0] v);
        @(negedge clock);
        ev = v;
        @(negedge clock);
        ev = 9'h000;
    endtask : pulse

    task automatic hot();
        @(negedge clock);
        hot_reset = 1'h1;
        @(negedge clock);
        hot_reset = 1'h0;
    endtask : hot

    always @(negedge clock) begin
        if (!reset && cfg_ack === 1'h1) begin
            if (exp_q.size() == 0) compare("cfg_ack", 32'h0, 32'h1);
            else compare("cfg_rdata", exp_q.pop_front(), cfg_rdata);
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            final_report();
        end
    end

    initial begin
        {hot_reset, cfg_req, cfg_write, cfg_smbus, next_ptr_lock} = 5'h00;
        {cfg_addr, cfg_be, cfg_wdata, ev, ack_delay} = '0;
        surprise_down_capable = 1'h1;
        for (int i = 0; i < 1024; i++) shadow[i] = 32'hC0DE0000 ^ i;
        repeat (2) @(posedge clock);
        @(negedge clock);
        reset = 1'h0;
        rd(`OFS_ERROR_CAP_HEADER, 32'h18010001);
        rd(`OFS_UNCORRECTABLE_STATUS, 32'h0);
        wr(`OFS_ERROR_CAP_HEADER, 4'hF, 32'h2AB00000);
        rd(`OFS_ERROR_CAP_HEADER, 32'h2AB10001);
        next_ptr_lock = 1'h1;
        wr(`OFS_ERROR_CAP_HEADER, 4'hF, 32'h0);
        rd(`OFS_ERROR_CAP_HEADER, 32'h2AB10001);
        next_ptr_lock = 1'h0;
        hot();
        rd(`OFS_ERROR_CAP_HEADER, 32'h18010001);
        exp_st = 32'h0;
        for (int i = 0; i < 9; i++) begin
            pulse(9'h001 << i);
            exp_st[pos[i]] = 1'h1;
            rd(`OFS_UNCORRECTABLE_STATUS, exp_st);
        end
        hot();
        rd(`OFS_UNCORRECTABLE_STATUS, exp_st);
        compare("uncorrectable_status_reg", exp_st, uncorrectable_status_reg);
        wr(`OFS_UNCORRECTABLE_STATUS, 4'h1, 32'hFFFFFFFF);
        rd(`OFS_UNCORRECTABLE_STATUS, exp_st & 32'hFFFFFFCF);
        wr(`OFS_UNCORRECTABLE_STATUS, 4'hF, 32'hFFFFFFFF);
        rd(`OFS_UNCORRECTABLE_STATUS, 32'h0);
        surprise_down_capable = 1'h0;
        pulse(9'h002);
        rd(`OFS_UNCORRECTABLE_STATUS, 32'h0);
        surprise_down_capable = 1'h1;
        wr(`OFS_WINDOW_POINTER, 4'hF, 32'hFFFFF104);
        rd(`OFS_WINDOW_POINTER, 32'h00000104);
        pulse(9'h104);
        rd(`OFS_WINDOW_DATA, 32'h00101000);
        wr(`OFS_WINDOW_DATA, 4'h4, 32'hFFFFFFFF);
        rd(`OFS_UNCORRECTABLE_STATUS, 32'h00001000);
        issue(1'h0, 1'h1, `OFS_WINDOW_DATA, 4'hF, 32'h0, 32'h0);
        issue(1'h1, 1'h1, `OFS_WINDOW_DATA, 4'hF, 32'hFFFFFFFF, 32'h0);
        settle();
        rd(`OFS_UNCORRECTABLE_STATUS, 32'h00001000);
        wr(`OFS_WINDOW_POINTER, 4'hF, 32'h000000FC);
        rd(`OFS_WINDOW_DATA, 32'h0);
        wr(`OFS_WINDOW_DATA, 4'hF, 32'h00000104);
        rd(`OFS_WINDOW_POINTER, 32'h000000FC);
        wr(`OFS_WINDOW_POINTER, 4'hF, 32'h000000F8);
        wr(`OFS_WINDOW_DATA, 4'hF, 32'h00000100);
        rd(`OFS_WINDOW_POINTER, 32'h00000100);
        rd(`OFS_WINDOW_DATA, 32'h18010001);
        rd(12'h200, 32'h0);
        issue(1'h0, 1'h0, `OFS_ERROR_CAP_HEADER, 4'hF, 32'h0, 32'h18010001);
        issue(1'h0, 1'h0, `OFS_ERROR_CAP_HEADER, 4'hF, 32'h0, 32'h18010001);
        settle();
        for (int n = 0; n < 8; n++) begin
            d = xorshift();
            a = {5'h00, d[4:0], 2'h0};
            ack_delay = {2'h0, d[9:8]};
            be = d[15:12];
            d = xorshift();
            wr(`OFS_WINDOW_POINTER, 4'hF, {20'h0, a});
            issue(1'h1, 1'h0, `OFS_WINDOW_DATA, be, d, 32'h0);
            issue(1'h0, 1'h0, `OFS_ERROR_CAP_HEADER, 4'hF, d, 32'h0, 1'b0);
            settle();
            for (int b = 0; b < 4; b++) if (be[b]) shadow[a[11:2]][8*b+:8] = d[8*b+:8];
            rd(`OFS_WINDOW_DATA, shadow[a[11:2]]);
        end
        final_report();
    end
endmodule : tb_ext_cfg_access_aer_status
